// ---- design/swr_sleep_wake_reset_control.sv ----
// sleep, wake, watchdog and reset bookkeeping with an AXI4-Lite register port
// assumes synchronous pins, a protected-write unlock level from the core and
// that rst_n_i is the power-on reset; warm resets are generated here
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module swr_sleep_wake_reset_control
	import swr_pkg::*;
#(
	parameter int WDOG_DIV = WDOG_DIVIDE,
	parameter int HOLD_CYCLES = RESET_HOLD_CYCLES,
	parameter int ADDR_W = 10
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic protected_unlock_i,
	input wire logic ext_reset_enable_i,
	input wire logic reset_pin_i,
	input wire logic usb_wake_event_i,
	input wire logic spi_wake_event_i,
	input wire logic first_serial_rx_pin_i,
	input wire logic first_serial_rx_alt_pin_i,
	input wire logic second_serial_rx_pin_i,
	input wire logic second_serial_rx_alt_pin_i,
	input wire logic [7:0] port1_pins_i,
	input wire logic [7:0] port3_pins_i,
	input wire logic watchdog_isr_enter_i,
	output logic sleep_o,
	output logic system_reset_n_o,
	output logic serial_baud_double_o,
	output logic watchdog_overflow_flag_o,
	output logic first_serial_pin_remap_o,
	output logic second_serial_pin_remap_o
);
	localparam int DIV_W = $clog2(WDOG_DIV);

	typedef struct packed {
		logic [7:0] power_control;
		logic [7:0] wake_source_enable;
		logic [7:0] reset_survive_scratch;
		logic [7:0] watchdog_counter;
		logic [DIV_W-1:0] wdog_div;
		logic [4:0] sys_control;
		logic watchdog_overflow_flag;
		logic port3_pin2_prev;
		swr_phase_type phase;
		logic [15:0] hold_cnt;
		logic sys_rst_n;
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [7:0] aw_idx;
		logic [7:0] w_data;
		logic w_lane;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} swr_state_type;

	localparam swr_state_type POR_STATE = '{
		power_control: PC_RESET,
		wake_source_enable: WAKE_RESET,
		reset_survive_scratch: SCRATCH_RESET,
		watchdog_counter: WDOG_RESET,
		wdog_div: '0,
		sys_control: SC_RESET,
		watchdog_overflow_flag: 1'b0,
		port3_pin2_prev: 1'b1,
		phase: SWR_RUN,
		hold_cnt: 16'h0000,
		sys_rst_n: 1'b1,
		awready: 1'b1,
		wready: 1'b1,
		aw_got: 1'b0,
		w_got: 1'b0,
		aw_idx: 8'h00,
		w_data: 8'h00,
		w_lane: 1'b0,
		bvalid: 1'b0,
		bresp: RESP_OKAY,
		arready: 1'b1,
		rvalid: 1'b0,
		rdata: 32'h0000_0000,
		rresp: RESP_OKAY
	};

	swr_state_type s;
	swr_state_type n;
	logic wr_fire;
	logic wdog_tick;
	logic wdog_overflow;
	logic wake_any;
	logic warm_start;
	logic [1:0] warm_cause;
	logic [7:0] rd_idx;
	logic first_rx;
	logic second_rx;

	function automatic logic mapped(input logic [7:0] idx);
		mapped = (idx == IDX_POWER_CONTROL) || (idx == IDX_WAKE_SOURCE_ENABLE) ||
			(idx == IDX_SYS_CONTROL) || (idx == IDX_SYS_STATUS) ||
			(idx == IDX_RESET_SURVIVE_SCRATCH) || (idx == IDX_WATCHDOG_COUNTER);
	endfunction

	always_comb begin
		n = s;
		rd_idx = s_axi_araddr_i[9:2];
		wr_fire = s.aw_got && s.w_got && !s.bvalid;
		// the remap selects pick which rx pin is watched
		first_rx = s.sys_control[SC_FIRST_SERIAL_PIN_REMAP] ?
			first_serial_rx_alt_pin_i : first_serial_rx_pin_i;
		second_rx = s.sys_control[SC_SECOND_SERIAL_PIN_REMAP] ?
			second_serial_rx_alt_pin_i : second_serial_rx_pin_i;
		wake_any = (s.wake_source_enable[WK_USB] && usb_wake_event_i) ||
			(s.wake_source_enable[WK_SECOND_SERIAL_RX] && !second_rx) ||
			(s.wake_source_enable[WK_PORT1_PIN5] && !port1_pins_i[5]) ||
			(s.wake_source_enable[WK_PORT1_PIN4] && !port1_pins_i[4]) ||
			(s.wake_source_enable[WK_PORT1_PIN3] && !port1_pins_i[3]) ||
			(s.wake_source_enable[WK_RESET_PIN_HIGH] && reset_pin_i) ||
			(s.wake_source_enable[WK_PORT3_PINS] &&
				((port3_pins_i[2] != s.port3_pin2_prev) || !port3_pins_i[3])) ||
			(s.wake_source_enable[WK_FIRST_SERIAL_RX] && !first_rx) ||
			(s.sys_control[SC_WAKE_ON_SPI] && spi_wake_event_i);
		wdog_tick = (s.wdog_div == DIV_W'(WDOG_DIV - 1));
		wdog_overflow = wdog_tick && (s.watchdog_counter == WDOG_TOP);
		n.port3_pin2_prev = port3_pins_i[2];

		// bus channels: address and data may arrive in either order
		if (s_axi_awvalid_i && s.awready) begin
			n.awready = 1'b0;
			n.aw_got = 1'b1;
			n.aw_idx = s_axi_awaddr_i[9:2];
		end
		if (s_axi_wvalid_i && s.wready) begin
			n.wready = 1'b0;
			n.w_got = 1'b1;
			n.w_data = s_axi_wdata_i[7:0];
			n.w_lane = s_axi_wstrb_i[0];
		end
		if (s.bvalid && s_axi_bready_i) begin
			n.bvalid = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end
		if (wr_fire) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = mapped(s.aw_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		if (s.rvalid && s_axi_rready_i) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end
		if (s_axi_arvalid_i && s.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rresp = mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
			n.rdata = 32'h0000_0000;
			unique case (rd_idx)
				IDX_POWER_CONTROL: n.rdata[7:0] = s.power_control;
				IDX_WAKE_SOURCE_ENABLE: n.rdata[7:0] = s.wake_source_enable;
				IDX_SYS_CONTROL: n.rdata[4:0] = s.sys_control;
				IDX_SYS_STATUS: n.rdata[2:0] = {s.phase == SWR_HOLD,
					s.power_control[PC_SLEEP_REQUEST], s.watchdog_overflow_flag};
				IDX_RESET_SURVIVE_SCRATCH: n.rdata[7:0] = s.reset_survive_scratch;
				IDX_WATCHDOG_COUNTER: n.rdata[7:0] = s.watchdog_counter;
				default: n.rdata = 32'h0000_0000;
			endcase
		end

		// watchdog runs free; a reload restarts the count from the written value
		n.wdog_div = wdog_tick ? '0 : s.wdog_div + 1'b1;
		if (wdog_tick)
			n.watchdog_counter = s.watchdog_counter + 8'h01;
		if (watchdog_isr_enter_i)
			n.watchdog_overflow_flag = 1'b0;

		// a wake event seen this cycle ends sleep before any new write lands
		if (s.power_control[PC_SLEEP_REQUEST] && wake_any)
			n.power_control[PC_SLEEP_REQUEST] = 1'b0;
		if (s.sys_control[SC_SOFTWARE_RESET_REQUEST])
			n.sys_control[SC_SOFTWARE_RESET_REQUEST] = 1'b0;

		if (wr_fire && s.w_lane && s.phase == SWR_RUN) begin
			unique case (s.aw_idx)
				IDX_POWER_CONTROL: n.power_control = (s.w_data & PC_WRITE_MASK) |
					(s.power_control & ~PC_WRITE_MASK);
				IDX_WAKE_SOURCE_ENABLE: begin
					if (protected_unlock_i)
						n.wake_source_enable = s.w_data;
				end
				IDX_SYS_CONTROL: n.sys_control = s.w_data[4:0];
				IDX_RESET_SURVIVE_SCRATCH: n.reset_survive_scratch = s.w_data;
				IDX_WATCHDOG_COUNTER: begin
					n.watchdog_counter = s.w_data;
					n.watchdog_overflow_flag = 1'b0;
				end
				default: n.rdata = n.rdata;
			endcase
		end
		// overflow set wins over a reload or isr clear in the same cycle
		if (wdog_overflow)
			n.watchdog_overflow_flag = 1'b1;

		// warm reset sources, pin first
		warm_cause = CAUSE_SOFTWARE;
		warm_start = 1'b0;
		if (ext_reset_enable_i && reset_pin_i) begin
			warm_start = 1'b1;
			warm_cause = CAUSE_RESET_PIN;
		end else if (wdog_overflow && s.sys_control[SC_WATCHDOG_RESET_ENABLE]) begin
			warm_start = 1'b1;
			warm_cause = CAUSE_WATCHDOG;
		end else if (s.sys_control[SC_SOFTWARE_RESET_REQUEST]) begin
			warm_start = 1'b1;
			warm_cause = CAUSE_SOFTWARE;
		end

		unique case (s.phase)
			SWR_RUN: n.sys_rst_n = 1'b1;
			SWR_HOLD: begin
				n.hold_cnt = s.hold_cnt - 16'h0001;
				if (s.hold_cnt == 16'h0000) begin
					n.phase = SWR_RUN;
					n.sys_rst_n = 1'b1;
				end
			end
		endcase
		// warm reset keeps scratch and the bus and loads the cause bits and overflow flag; everything else returns to reset
		if (warm_start) begin
			n.phase = SWR_HOLD;
			n.hold_cnt = 16'(HOLD_CYCLES - 1);
			n.sys_rst_n = 1'b0;
			n.power_control = PC_RESET;
			n.power_control[PC_RESET_CAUSE_HIGH] = warm_cause[1];
			n.power_control[PC_RESET_CAUSE_LOW] = warm_cause[0];
			n.wake_source_enable = WAKE_RESET;
			n.sys_control = SC_RESET;
			n.watchdog_counter = WDOG_RESET;
			n.wdog_div = '0;
			n.watchdog_overflow_flag = wdog_overflow;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			s <= POR_STATE;
		else
			s <= n;
	end

	assign s_axi_awready_o = s.awready;
	assign s_axi_wready_o = s.wready;
	assign s_axi_bvalid_o = s.bvalid;
	assign s_axi_bresp_o = s.bresp;
	assign s_axi_arready_o = s.arready;
	assign s_axi_rvalid_o = s.rvalid;
	assign s_axi_rdata_o = s.rdata;
	assign s_axi_rresp_o = s.rresp;
	assign sleep_o = s.power_control[PC_SLEEP_REQUEST];
	assign system_reset_n_o = s.sys_rst_n;
	assign serial_baud_double_o = s.power_control[PC_SERIAL_BAUD_DOUBLE];
	assign watchdog_overflow_flag_o = s.watchdog_overflow_flag;
	assign first_serial_pin_remap_o = s.sys_control[SC_FIRST_SERIAL_PIN_REMAP];
	assign second_serial_pin_remap_o = s.sys_control[SC_SECOND_SERIAL_PIN_REMAP];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence usb_wake_seen;
		s.power_control[PC_SLEEP_REQUEST] && s.wake_source_enable[WK_USB] && usb_wake_event_i;
	endsequence
	sequence locked_wake_write;
		wr_fire && s.aw_idx == IDX_WAKE_SOURCE_ENABLE && !protected_unlock_i;
	endsequence
	sequence wdog_reset_fire;
		wdog_overflow && s.sys_control[SC_WATCHDOG_RESET_ENABLE] &&
			!(ext_reset_enable_i && reset_pin_i);
	endsequence
	// a power control write in the wake cycle wins, so such cycles are left out
	sequence asleep_quiet;
		sleep_o && !warm_start && !(wr_fire && s.aw_idx == IDX_POWER_CONTROL);
	endsequence
	sequence sleep_write;
		wr_fire && s.w_lane && s.aw_idx == IDX_POWER_CONTROL &&
			s.w_data[PC_SLEEP_REQUEST] && s.phase == SWR_RUN && !warm_start;
	endsequence
	sequence rx0_low;
		s.wake_source_enable[WK_FIRST_SERIAL_RX] &&
			!(first_serial_pin_remap_o ? first_serial_rx_alt_pin_i : first_serial_rx_pin_i);
	endsequence
	sequence rx1_low;
		s.wake_source_enable[WK_SECOND_SERIAL_RX] &&
			!(second_serial_pin_remap_o ? second_serial_rx_alt_pin_i : second_serial_rx_pin_i);
	endsequence
	sequence port1_low;
		|(s.wake_source_enable[WK_PORT1_PIN5:WK_PORT1_PIN3] & ~port1_pins_i[5:3]);
	endsequence
	sequence rst_pin_high;
		s.wake_source_enable[WK_RESET_PIN_HIGH] && reset_pin_i;
	endsequence
	sequence port3_active;
		s.wake_source_enable[WK_PORT3_PINS] && ($changed(port3_pins_i[2]) || !port3_pins_i[3]);
	endsequence

	AST_WAKE_CLEARS_SLEEP: assert property (usb_wake_seen ##0 asleep_quiet |=> !sleep_o)
		else $error("usb wake did not clear sleep");
	AST_RUN_AFTER_WARM: assert property ($rose(system_reset_n_o) |-> !sleep_o)
		else $error("device asleep after reset release");
	AST_WAKE_LOCKED: assert property (locked_wake_write ##0 !warm_start
		|=> $stable(s.wake_source_enable))
		else $error("locked write changed wake enables");
	AST_WDOG_FLAG: assert property (wdog_overflow |=> watchdog_overflow_flag_o)
		else $error("overflow did not set watchdog flag");
	AST_WDOG_RESET: assert property (wdog_reset_fire |=> !system_reset_n_o
		&& s.power_control[5:4] == CAUSE_WATCHDOG)
		else $error("watchdog reset or cause missing");
	AST_HOLD_LENGTH: assert property ($fell(system_reset_n_o) |-> (!system_reset_n_o) [*4])
		else $error("warm reset released too soon");
	AST_SCRATCH_KEPT: assert property ($fell(system_reset_n_o)
		|-> s.reset_survive_scratch == $past(s.reset_survive_scratch))
		else $error("scratch lost on warm reset");
	AST_RESERVED_ZERO: assert property (!s.power_control[6] && !s.power_control[0])
		else $error("reserved power control bits set");
	AST_WDOG_STEP: assert property (wdog_tick && !warm_start && !wr_fire
		|=> s.watchdog_counter == $past(s.watchdog_counter) + 8'h01)
		else $error("watchdog did not advance on tick");
	AST_SLEEP_SET: assert property (sleep_write |=> sleep_o)
		else $error("sleep write did not set sleep");
	AST_RX0_WAKE: assert property (asleep_quiet ##0 rx0_low |=> !sleep_o)
		else $error("first serial rx low did not wake");
	AST_RX1_WAKE: assert property (asleep_quiet ##0 rx1_low |=> !sleep_o)
		else $error("second serial rx low did not wake");
	AST_PORT1_WAKE: assert property (asleep_quiet ##0 port1_low |=> !sleep_o)
		else $error("port1 pin low did not wake");
	AST_RST_PIN_WAKE: assert property (asleep_quiet ##0 rst_pin_high |=> !sleep_o)
		else $error("reset pin high did not wake");
	AST_PORT3_WAKE: assert property (asleep_quiet ##0 port3_active |=> !sleep_o)
		else $error("port3 pin activity did not wake");
	AST_CAUSE_HELD: assert property (wr_fire && !warm_start |=>
		$stable(s.power_control[PC_RESET_CAUSE_HIGH:PC_RESET_CAUSE_LOW]))
		else $error("write changed reset cause bits");
endmodule // swr_sleep_wake_reset_control

// ---- design/swr_pkg.sv ----
// constants for the sleep, wake and reset control block
// assumes a 25 MHz system clock and a 32-bit AXI4-Lite register port
package swr_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	// warm reset hold time, rounded up to whole cycles
	localparam int RESET_HOLD_NS = 640;
	localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WDOG_DIVIDE = 65536;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
	localparam logic [7:0] IDX_WAKE_SOURCE_ENABLE = 8'hA9;
	localparam logic [7:0] IDX_SYS_CONTROL = 8'hB0;
	localparam logic [7:0] IDX_SYS_STATUS = 8'hB1;
	localparam logic [7:0] IDX_RESET_SURVIVE_SCRATCH = 8'hFE;
	localparam logic [7:0] IDX_WATCHDOG_COUNTER = 8'hFF;

	// power_control fields
	localparam int PC_SERIAL_BAUD_DOUBLE = 7;
	localparam int PC_RESET_CAUSE_HIGH = 5;
	localparam int PC_RESET_CAUSE_LOW = 4;
	localparam int PC_GENERAL_FLAG_ONE = 3;
	localparam int PC_GENERAL_FLAG_ZERO = 2;
	localparam int PC_SLEEP_REQUEST = 1;
	localparam logic [7:0] PC_RESET = 8'h10;
	localparam logic [7:0] PC_WRITE_MASK = 8'h8E;

	// wake_source_enable fields
	localparam int WK_USB = 7;
	localparam int WK_SECOND_SERIAL_RX = 6;
	localparam int WK_PORT1_PIN5 = 5;
	localparam int WK_PORT1_PIN4 = 4;
	localparam int WK_PORT1_PIN3 = 3;
	localparam int WK_RESET_PIN_HIGH = 2;
	localparam int WK_PORT3_PINS = 1;
	localparam int WK_FIRST_SERIAL_RX = 0;
	localparam logic [7:0] WAKE_RESET = 8'h00;

	// sys_control fields
	localparam int SC_WATCHDOG_RESET_ENABLE = 0;
	localparam int SC_FIRST_SERIAL_PIN_REMAP = 1;
	localparam int SC_SECOND_SERIAL_PIN_REMAP = 2;
	localparam int SC_SOFTWARE_RESET_REQUEST = 3;
	localparam int SC_WAKE_ON_SPI = 4;
	localparam logic [4:0] SC_RESET = 5'h00;
	// sys_status fields
	localparam int ST_WATCHDOG_OVERFLOW_FLAG = 0;
	localparam int ST_ASLEEP = 1;
	localparam int ST_IN_RESET_HOLD = 2;

	localparam logic [7:0] SCRATCH_RESET = 8'h00;
	localparam logic [7:0] WDOG_RESET = 8'h00;
	localparam logic [7:0] WDOG_TOP = 8'hFF;

	localparam logic [1:0] CAUSE_SOFTWARE = 2'h0;
	localparam logic [1:0] CAUSE_POWER_ON = 2'h1;
	localparam logic [1:0] CAUSE_WATCHDOG = 2'h2;
	localparam logic [1:0] CAUSE_RESET_PIN = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {SWR_RUN, SWR_HOLD} swr_phase_type;
endpackage

// ---- test/tb_top.sv ----
// bench for the sleep, wake, watchdog and reset block, with a bench-side register model
// assumes the design package and a single 25 MHz clock; shortened watchdog and hold counts
`timescale 1ns/1ps
module tb_top;
	import swr_pkg::*;
	localparam int DIV = 16;
	localparam int HOLD = 4;
	logic clk_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready, unlock, ext_en, rst_pin;
	logic usb, spi, rx0, rx0a, rx1, rx1a, isr, awready, wready, bvalid, arready, rvalid;
	logic sleep, sys_rst_n, baud, wdf, remap0, remap1;
	logic [9:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [7:0] p1, p3;
	logic [1:0] bresp, rresp, rs;
	int error_cnt, checks_done, seed, m_pc, m_wk, m_scr, n;
	int enm[12] = '{1, 2, 4, 8, 16, 32, 64, 128, 1, 64, 2, 0};
	int scm[12] = '{0, 0, 0, 0, 0, 0, 0, 0, 2, 4, 0, 16};

	swr_sleep_wake_reset_control #(.WDOG_DIV(DIV), .HOLD_CYCLES(HOLD)) dut_u (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.protected_unlock_i(unlock), .ext_reset_enable_i(ext_en), .reset_pin_i(rst_pin),
		.usb_wake_event_i(usb), .spi_wake_event_i(spi), .first_serial_rx_pin_i(rx0),
		.first_serial_rx_alt_pin_i(rx0a), .second_serial_rx_pin_i(rx1),
		.second_serial_rx_alt_pin_i(rx1a), .port1_pins_i(p1), .port3_pins_i(p3),
		.watchdog_isr_enter_i(isr), .sleep_o(sleep), .system_reset_n_o(sys_rst_n),
		.serial_baud_double_o(baud), .watchdog_overflow_flag_o(wdf),
		.first_serial_pin_remap_o(remap0), .second_serial_pin_remap_o(remap1)
	);

	initial begin
		clk_i = 0;
		forever #20 clk_i = ~clk_i;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %0h expected %0h", $time, got, exp);
		end
	endtask

	task conclude;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	// write; the model follows what the register should keep
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			t++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && t < 40);
		bready <= 1'b0;
		rs = bresp;
		if (t >= 40) error_cnt++;
		if (idx == IDX_POWER_CONTROL) m_pc = (m_pc & 8'h30) | (d & PC_WRITE_MASK);
		if (idx == IDX_WAKE_SOURCE_ENABLE && unlock) m_wk = d;
		if (idx == IDX_RESET_SURVIVE_SCRATCH) m_scr = d;
	endtask

	task automatic rd(input logic [7:0] idx);
		int t;
		t = 0;
		@(posedge clk_i);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			t++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && t < 40);
		rready <= 1'b0;
		rv = rdata;
		rs = rresp;
		if (t >= 40) error_cnt++;
	endtask

	task chkr(input logic [7:0] idx, input int exp);
		rd(idx);
		chk(rv, 32'(exp));
	endtask

	// drive one wake source active or idle; pins idle high except the reset pin, which idles low with the events
	task src(input int k, input logic a);
		@(posedge clk_i);
		case (k)
			0: rx0 <= ~a;
			1: p3[3] <= ~a;
			2: rst_pin <= a;
			3: p1[3] <= ~a;
			4: p1[4] <= ~a;
			5: p1[5] <= ~a;
			6: rx1 <= ~a;
			7: usb <= a;
			8: rx0a <= ~a;
			9: rx1a <= ~a;
			10: p3[2] <= ~a;
			default: spi <= a;
		endcase
	endtask

	// waits for a warm reset to start, then counts its low cycles into n
	task wrst;
		n = 0;
		while (sys_rst_n !== 1'b0 && n < 400) begin
			cyc(1);
			n++;
		end
		if (n >= 400) error_cnt++;
		n = 0;
		while (sys_rst_n === 1'b0 && n < 100) begin
			cyc(1);
			n++;
		end
		if (n >= 100) error_cnt++;
	endtask

	initial begin
		cyc(20000);
		error_cnt++;
		conclude;
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, ext_en, rst_pin, usb, spi, isr} = '0;
		{rx0, rx0a, rx1, rx1a, unlock} = '1;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'h1;
		p1 = 8'hFF;
		p3 = 8'hFF;
		seed = 75615;
		rst_n_i = 1'b0;
		m_pc = 8'h10;
		cyc(8);
		rst_n_i <= 1'b1;
		chk(32'(sleep), 0);
		chkr(IDX_POWER_CONTROL, m_pc);
		chkr(IDX_WATCHDOG_COUNTER, 0);
		wr(IDX_POWER_CONTROL, 8'hFD);
		chkr(IDX_POWER_CONTROL, m_pc);
		chk(32'(baud), 1);
		wr(IDX_POWER_CONTROL, 8'h41);
		chkr(IDX_POWER_CONTROL, m_pc);
		chk(32'(baud), 0);
		wr(8'h10, 8'h55);
		chk(32'(rs), 32'(RESP_SLVERR));
		rd(8'h10);
		chk(32'(rs), 32'(RESP_SLVERR));
		unlock <= 1'b0;
		wr(IDX_WAKE_SOURCE_ENABLE, 8'($random(seed)));
		chkr(IDX_WAKE_SOURCE_ENABLE, m_wk);
		unlock <= 1'b1;
		wr(IDX_WAKE_SOURCE_ENABLE, 8'($random(seed)));
		chkr(IDX_WAKE_SOURCE_ENABLE, m_wk);
		wr(IDX_RESET_SURVIVE_SCRATCH, 8'($random(seed)));
		chkr(IDX_RESET_SURVIVE_SCRATCH, m_scr);
		for (int k = 0; k < 12; k++) begin
			// all other wake_source_enable sources on, this one and spi off: a stray wake shows here
			wr(IDX_SYS_CONTROL, 8'(scm[k] & 8'hEF));
			wr(IDX_WAKE_SOURCE_ENABLE, 8'(~enm[k]));
			wr(IDX_POWER_CONTROL, 8'h02);
			src(k, 1);
			cyc(3);
			chk(32'(sleep), 1);
			src(k, 0);
			wr(IDX_SYS_CONTROL, 8'(scm[k]));
			chk(32'({remap1, remap0}), 32'((scm[k] >> 1) & 3));
			wr(IDX_WAKE_SOURCE_ENABLE, 8'(enm[k]));
			src(k, 1);
			cyc(3);
			chk(32'(sleep), 0);
			src(k, 0);
			m_pc = m_pc & 8'hFD;
			chkr(IDX_POWER_CONTROL, m_pc);
		end
		wr(IDX_SYS_CONTROL, 8'h00);
		wr(IDX_WATCHDOG_COUNTER, 8'hFE);
		n = 0;
		while (wdf !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		chk(32'(n > DIV && n <= 2 * DIV + 3), 1);
		chkr(IDX_WATCHDOG_COUNTER, 0);
		isr <= 1'b1;
		cyc(1);
		isr <= 1'b0;
		cyc(2);
		chk(32'(wdf), 0);
		wr(IDX_WATCHDOG_COUNTER, 8'hFF);
		cyc(DIV + 3);
		chk(32'(wdf), 1);
		wr(IDX_WATCHDOG_COUNTER, 8'h80);
		cyc(1);
		chk(32'(wdf), 0);
		rd(IDX_WATCHDOG_COUNTER);
		chk(32'(rv[7:1]), 32'h40);
		wr(IDX_SYS_CONTROL, 8'h01);
		wr(IDX_WATCHDOG_COUNTER, 8'hFE);
		wrst;
		chk(32'(n), HOLD);
		wr(IDX_SYS_CONTROL, 8'h00);
		m_pc = {2'h0, CAUSE_WATCHDOG, 4'h0};
		chkr(IDX_POWER_CONTROL, m_pc);
		chkr(IDX_RESET_SURVIVE_SCRATCH, m_scr);
		wr(IDX_SYS_CONTROL, 8'h08);
		wrst;
		m_pc = {2'h0, CAUSE_SOFTWARE, 4'h0};
		chkr(IDX_POWER_CONTROL, m_pc);
		ext_en <= 1'b1;
		rst_pin <= 1'b1;
		cyc(2);
		rst_pin <= 1'b0;
		wrst;
		ext_en <= 1'b0;
		m_pc = {2'h0, CAUSE_RESET_PIN, 4'h0};
		chkr(IDX_POWER_CONTROL, m_pc);
		chkr(IDX_RESET_SURVIVE_SCRATCH, m_scr);
		// power-on reset is the only one that clears the scratch byte
		rst_n_i <= 1'b0;
		cyc(2);
		rst_n_i <= 1'b1;
		chkr(IDX_RESET_SURVIVE_SCRATCH, 0);
		chkr(IDX_POWER_CONTROL, 8'h10);
		chkr(IDX_WAKE_SOURCE_ENABLE, 0);
		conclude;
	end
endmodule // tb_top
